// ### rtl/pbv_cfg.svh
// Constants for the bridge decode and ordering block: commands, windows and depths.
`ifndef PBV_CFG_SVH
`define PBV_CFG_SVH

// ****************************************************************
// Bus command codes
// ****************************************************************
`define PBV_CMD_IO_RD   4'h2
`define PBV_CMD_IO_WR   4'h3
`define PBV_CMD_MEM_RD  4'h6
`define PBV_CMD_MEM_WR  4'h7
`define PBV_CMD_CFG_RD  4'hA
`define PBV_CMD_CFG_WR  4'hB
`define PBV_CMD_MEM_RDM 4'hC
`define PBV_CMD_MEM_RDL 4'hE
`define PBV_CMD_MEM_WRI 4'hF

// ****************************************************************
// Legacy display windows
// ****************************************************************
`define PBV_FB_LO       32'h000A_0000
`define PBV_FB_HI       32'h000B_FFFF
`define PBV_IO_A_LO     10'h3B0
`define PBV_IO_A_HI     10'h3BB
`define PBV_IO_B_LO     10'h3C0
`define PBV_IO_B_HI     10'h3DF
`define PBV_PAL_MASK    10'h3C6
`define PBV_PAL_WADDR   10'h3C8
`define PBV_PAL_DATA    10'h3C9
`define PBV_BIOS_PAGE   16'h000C

// ****************************************************************
// Buffer sizes
// ****************************************************************
`define PBV_PW_DEPTH    4

`endif

// ### rtl/pbv_pkg.sv
// Types shared by the bridge decode and ordering block.
package pbv_pkg;

    // ****************************************************************
    // Delayed transaction slot states
    // ****************************************************************
    typedef enum logic [2:0]
    {
        PBV_DLY_IDLE = 3'h1,
        PBV_DLY_WAIT = 3'h2,
        PBV_DLY_HELD = 3'h4
    } pbv_dly_state_t;

    // ****************************************************************
    // One posted write as it sits in the buffer
    // ****************************************************************
    typedef struct packed
    {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] data;
    } pbv_txn_t;

endpackage

// ### rtl/pbv_bridge.sv
// Bridge forwarding decode, posted write buffering and transaction ordering.
// What this block does
// R1: VGA mode forwards frame buffer and VGA ports downstream, ignoring range hits.
// R2: VGA mode stops upstream claiming of VGA memory and port addresses.
// R3: Frame buffer window is A0000h through BFFFFh inclusive.
// R4: Frame buffer reads go as one data phase with byte enables unchanged.
// R5: VGA ports are 3B0h-3BBh and 3C0h-3DFh.
// R6: Port decode ignores bits 15:10 and needs bits 31:16 zero.
// R7: The BIOS area at C0000h is never decoded by VGA mode.
// R8: Snoop mode forwards writes to palette ports 3C6h, 3C8h, 3C9h.
// R9: Snooped palette writes are actively claimed on the primary bus.
// R10: Mode and snoop both set decode exactly like mode alone.
// R11: Memory writes are posted and finish once buffered.
// R12: I/O and config writes are retried and queued as delayed writes.
// R13: A delayed write finishes at its source only after its destination.
// R14: The destination response is held and returned as a completion.
// R15: All reads are retried, queued, and their data held as completions.
// R16: Writes are never combined, merged or collapsed.
// R17: Ordering is fixed only when a transaction ends without retry.
// R18: Retried requests may finish in any order among themselves.
// R19: Initiators needing order issue one delayed request and repeat fairly.
// R20: The two directions are independent and post writes concurrently.
// R21: Posted writes are accepted whatever delayed work is pending.
// R22: Posted writes leave in the order they were accepted.
// R23: A delayed request waits for all earlier same-direction posted writes.
// R24: Port decode uses I/O commands, window decode memory, snoop I/O writes.
`timescale 1ns/1ps
`include "pbv_cfg.svh"

// ****************************************************************
// Posted write buffer
// ****************************************************************
module pbv_fifo #(
    parameter int W = 72,
    parameter int D = `PBV_PW_DEPTH
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   wr_valid_i,
    output logic                        wr_ready_o,
    input  wire logic [W-1:0]           wr_data_i,
    output logic                        rd_valid_o,
    input  wire logic                   rd_ready_i,
    output logic [W-1:0]                rd_data_o,
    output logic [$clog2(D+1)-1:0]      count_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D+1);
    logic [W-1:0]  mem_reg [D];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [CW-1:0] cnt_reg;
    logic          push;
    logic          pop;

    assign wr_ready_o = (cnt_reg != CW'(D));
    assign rd_valid_o = (cnt_reg != '0);
    assign rd_data_o  = mem_reg[rptr_reg];
    assign count_o    = cnt_reg;
    assign push       = wr_valid_i && wr_ready_o;
    assign pop        = rd_valid_o && rd_ready_i;

    // Each accepted write owns one entry, so nothing is ever folded together.
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_reg[wptr_reg] <= wr_data_i; // [R16]
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end
        else
        begin
            if (push)
                wptr_reg <= (wptr_reg == AW'(D - 1)) ? '0 : wptr_reg + AW'(1);
            if (pop)
                rptr_reg <= (rptr_reg == AW'(D - 1)) ? '0 : rptr_reg + AW'(1); // [R22]
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end
endmodule

// ****************************************************************
// One crossing direction: posted buffer, delayed slot, launch stage
// ****************************************************************
module pbv_dir #(
    parameter int D = `PBV_PW_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        in_valid_i,
    input  wire logic        in_fwd_i,
    input  wire logic [3:0]  in_cmd_i,
    input  wire logic [31:0] in_addr_i,
    input  wire logic [3:0]  in_be_i,
    input  wire logic [31:0] in_data_i,
    output logic             in_done_o,
    output logic             in_retry_o,
    output logic [31:0]      in_rdata_o,
    output logic             out_valid_o,
    output logic [3:0]       out_cmd_o,
    output logic [31:0]      out_addr_o,
    output logic [3:0]       out_be_o,
    output logic [31:0]      out_data_o,
    input  wire logic        out_ready_i,
    input  wire logic [31:0] out_rdata_i
);
    localparam int CW = $clog2(D+1);
    pbv_pkg::pbv_dly_state_t state_reg;
    pbv_pkg::pbv_txn_t       dly_reg;
    pbv_pkg::pbv_txn_t       head;
    logic [CW-1:0] fifo_cnt;
    logic [CW-1:0] ahead_reg;
    logic [31:0]   cmpl_reg;
    logic          fifo_wr_ready;
    logic          fifo_rd_valid;
    logic          sent_reg;
    logic          fair_reg;
    logic          out_valid_reg;
    logic          out_dly_reg;
    logic          is_posted;
    logic          is_dly;
    logic          take;
    logic          push;
    logic          match;
    logic          dly_finish;
    logic          elig_p;
    logic          elig_d;
    logic          grant_p;
    logic          grant_d;
    logic          out_fire;

    assign is_posted = (in_cmd_i == `PBV_CMD_MEM_WR) || (in_cmd_i == `PBV_CMD_MEM_WRI); // [R11]
    assign is_dly    = (in_cmd_i == `PBV_CMD_IO_WR) || (in_cmd_i == `PBV_CMD_CFG_WR) // [R12]
                    || (in_cmd_i == `PBV_CMD_IO_RD) || (in_cmd_i == `PBV_CMD_CFG_RD) // [R15]
                    || (in_cmd_i == `PBV_CMD_MEM_RD) || (in_cmd_i == `PBV_CMD_MEM_RDM)
                    || (in_cmd_i == `PBV_CMD_MEM_RDL);
    assign take      = in_valid_i && in_fwd_i;
    // Acceptance looks only at buffer space, never at the delayed slot.
    assign push      = take && is_posted && fifo_wr_ready; // [R21]
    assign match     = (dly_reg.cmd == in_cmd_i) && (dly_reg.addr == in_addr_i)
                    && (dly_reg.be == in_be_i) && (dly_reg.data == in_data_i);
    assign dly_finish = take && is_dly && (state_reg == pbv_pkg::PBV_DLY_HELD) && match; // [R13]
    // Only a non-retry ending fixes a transaction's place in the order.
    assign in_done_o  = push || dly_finish; // [R17]
    assign in_retry_o = (take && is_posted && !fifo_wr_ready) || (take && is_dly && !dly_finish); // [R12]
    assign in_rdata_o = cmpl_reg;

    pbv_fifo #(
        .W ($bits(pbv_pkg::pbv_txn_t)),
        .D (D)
    ) u_fifo (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .wr_valid_i (take && is_posted),
        .wr_ready_o (fifo_wr_ready),
        .wr_data_i  ({in_cmd_i, in_addr_i, in_be_i, in_data_i}),
        .rd_valid_o (fifo_rd_valid),
        .rd_ready_i (grant_p),
        .rd_data_o  (head),
        .count_o    (fifo_cnt)
    );

    // A delayed request may leave only when every older posted write has gone.
    assign elig_p  = fifo_rd_valid && !out_valid_reg;
    assign elig_d  = (state_reg == pbv_pkg::PBV_DLY_WAIT) && !sent_reg && (ahead_reg == '0) && !out_valid_reg; // [R23]
    // Alternating turns let posted writes pass a stuck delayed request.
    assign grant_d = elig_d && (fair_reg || !elig_p);
    assign grant_p = elig_p && !grant_d;
    assign out_fire = out_valid_reg && out_ready_i;
    assign out_valid_o = out_valid_reg;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fair_reg <= 1'b0;
        else if (grant_d)
            fair_reg <= 1'b0;
        else if (grant_p && (state_reg == pbv_pkg::PBV_DLY_WAIT))
            fair_reg <= 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            out_valid_reg <= 1'b0;
            out_dly_reg   <= 1'b0;
            out_cmd_o     <= '0;
            out_addr_o    <= '0;
            out_be_o      <= '0;
            out_data_o    <= '0;
        end
        else if (grant_p || grant_d)
        begin
            out_valid_reg <= 1'b1;
            out_dly_reg   <= grant_d;
            out_cmd_o     <= grant_d ? dly_reg.cmd  : head.cmd;
            out_addr_o    <= grant_d ? dly_reg.addr : head.addr;
            out_be_o      <= grant_d ? dly_reg.be   : head.be; // [R4]
            out_data_o    <= grant_d ? dly_reg.data : head.data;
        end
        else if (out_fire)
            out_valid_reg <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ahead_reg <= '0;
        else if ((state_reg == pbv_pkg::PBV_DLY_IDLE) && take && is_dly)
            ahead_reg <= fifo_cnt - CW'(grant_p);
        else if (grant_p && (ahead_reg != '0))
            ahead_reg <= ahead_reg - CW'(1);
    end

    // One slot: any retried request may win it, so retried ones finish in any order.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= pbv_pkg::PBV_DLY_IDLE;
            dly_reg   <= '0;
            sent_reg  <= 1'b0;
            cmpl_reg  <= '0;
        end
        else
        begin
            unique case (state_reg)
                pbv_pkg::PBV_DLY_IDLE:
                    if (take && is_dly)
                    begin
                        state_reg <= pbv_pkg::PBV_DLY_WAIT; // [R18]
                        dly_reg   <= {in_cmd_i, in_addr_i, in_be_i, in_data_i};
                        sent_reg  <= 1'b0;
                    end
                pbv_pkg::PBV_DLY_WAIT:
                begin
                    if (grant_d)
                        sent_reg <= 1'b1;
                    if (out_fire && out_dly_reg)
                    begin
                        state_reg <= pbv_pkg::PBV_DLY_HELD; // [R14]
                        cmpl_reg  <= out_rdata_i; // [R15]
                    end
                end
                pbv_pkg::PBV_DLY_HELD:
                    if (dly_finish)
                        state_reg <= pbv_pkg::PBV_DLY_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_posted_accept: assert property (take && is_posted && (fifo_cnt < CW'(D)) |-> in_done_o && !in_retry_o) // [R21]
        else $error("Posted write refused with room in the buffer.");
    a_dly_retry_first: assert property ((state_reg == pbv_pkg::PBV_DLY_IDLE) && take && is_dly
        |-> in_retry_o ##1 (state_reg == pbv_pkg::PBV_DLY_WAIT)) // [R12]
        else $error("Delayed request not retried and queued.");
    a_dly_done_late: assert property (in_done_o && !is_posted |-> (state_reg == pbv_pkg::PBV_DLY_HELD) && sent_reg) // [R13]
        else $error("Delayed request finished before its destination.");
    a_read_behind_writes: assert property (grant_d |-> (ahead_reg == '0) && !out_valid_reg) // [R23]
        else $error("Delayed request passed an older posted write.");
    a_cmpl_capture: assert property (out_fire && out_dly_reg
        |=> (state_reg == pbv_pkg::PBV_DLY_HELD) && (in_rdata_o == $past(out_rdata_i))) // [R14]
        else $error("Completion not held after destination finished.");
    a_be_unchanged: assert property (grant_d |=> out_valid_o && (out_be_o == dly_reg.be) && (out_cmd_o == dly_reg.cmd)) // [R4]
        else $error("Delayed request launched with altered enables.");
    a_posted_one_each: assert property (push |=> (fifo_cnt == $past(fifo_cnt) + CW'(1) - CW'($past(grant_p)))) // [R16]
        else $error("Posted write not kept as its own entry.");

    c_posted: cover property (push ##[1:20] out_fire);
    c_dly_round: cover property ((state_reg == pbv_pkg::PBV_DLY_IDLE) && take && is_dly ##[1:40] dly_finish);
    c_full_retry: cover property (take && is_posted && !fifo_wr_ready);
endmodule

// ****************************************************************
// Top: address decode for both sides and two independent directions
// ****************************************************************
module pbv_bridge #(
    parameter int D = `PBV_PW_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        vga_mode_i,
    input  wire logic        vga_snoop_i,
    input  wire logic        p_valid_i,
    input  wire logic [3:0]  p_cmd_i,
    input  wire logic [31:0] p_addr_i,
    input  wire logic [3:0]  p_be_i,
    input  wire logic [31:0] p_data_i,
    input  wire logic        p_range_hit_i,
    output logic             p_devsel_o,
    output logic             p_done_o,
    output logic             p_retry_o,
    output logic [31:0]      p_rdata_o,
    input  wire logic        s_valid_i,
    input  wire logic [3:0]  s_cmd_i,
    input  wire logic [31:0] s_addr_i,
    input  wire logic [3:0]  s_be_i,
    input  wire logic [31:0] s_data_i,
    input  wire logic        s_range_hit_i,
    output logic             s_devsel_o,
    output logic             s_done_o,
    output logic             s_retry_o,
    output logic [31:0]      s_rdata_o,
    output logic             down_valid_o,
    output logic [3:0]       down_cmd_o,
    output logic [31:0]      down_addr_o,
    output logic [3:0]       down_be_o,
    output logic [31:0]      down_data_o,
    input  wire logic        down_ready_i,
    input  wire logic [31:0] down_rdata_i,
    output logic             up_valid_o,
    output logic [3:0]       up_cmd_o,
    output logic [31:0]      up_addr_o,
    output logic [3:0]       up_be_o,
    output logic [31:0]      up_data_o,
    input  wire logic        up_ready_i,
    input  wire logic [31:0] up_rdata_i
);
    logic p_vga;
    logic p_snoop;
    logic p_fwd;
    logic s_vga;
    logic s_fwd;

    // Ports alias every 1KB: bits 15:10 are dropped, bits 31:16 must be zero.
    function automatic logic vga_hit(input logic [3:0] cmd, input logic [31:0] a);
        logic io;
        logic mem;
        io  = (cmd == `PBV_CMD_IO_RD) || (cmd == `PBV_CMD_IO_WR); // [R24]
        mem = (cmd == `PBV_CMD_MEM_RD) || (cmd == `PBV_CMD_MEM_RDM) || (cmd == `PBV_CMD_MEM_RDL)
           || (cmd == `PBV_CMD_MEM_WR) || (cmd == `PBV_CMD_MEM_WRI);
        return (io && (a[31:16] == 16'h0000) // [R6]
                && (((a[9:0] >= `PBV_IO_A_LO) && (a[9:0] <= `PBV_IO_A_HI))
                 || ((a[9:0] >= `PBV_IO_B_LO) && (a[9:0] <= `PBV_IO_B_HI)))) // [R5]
            || (mem && (a >= `PBV_FB_LO) && (a <= `PBV_FB_HI)); // [R3]
    endfunction

    // The window stops at BFFFFh, so the BIOS page above it never matches.
    assign p_vga   = vga_mode_i && vga_hit(p_cmd_i, p_addr_i); // [R7]
    // Mode set makes snoop redundant, so snoop only adds when mode is clear.
    assign p_snoop = vga_snoop_i && !vga_mode_i && (p_cmd_i == `PBV_CMD_IO_WR) // [R10]
                  && (p_addr_i[31:16] == 16'h0000)
                  && ((p_addr_i[9:0] == `PBV_PAL_MASK) || (p_addr_i[9:0] == `PBV_PAL_WADDR)
                   || (p_addr_i[9:0] == `PBV_PAL_DATA)); // [R8]
    assign p_fwd   = p_range_hit_i || p_vga || p_snoop; // [R1]
    assign s_vga   = vga_mode_i && vga_hit(s_cmd_i, s_addr_i);
    assign s_fwd   = !s_range_hit_i && !s_vga; // [R2]
    assign p_devsel_o = p_valid_i && p_fwd; // [R9]
    assign s_devsel_o = s_valid_i && s_fwd;

    // Two separate engines: no ordering couples the directions.
    pbv_dir #(.D (D)) u_down ( // [R20]
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (p_valid_i),
        .in_fwd_i    (p_fwd),
        .in_cmd_i    (p_cmd_i),
        .in_addr_i   (p_addr_i),
        .in_be_i     (p_be_i),
        .in_data_i   (p_data_i),
        .in_done_o   (p_done_o),
        .in_retry_o  (p_retry_o),
        .in_rdata_o  (p_rdata_o),
        .out_valid_o (down_valid_o),
        .out_cmd_o   (down_cmd_o),
        .out_addr_o  (down_addr_o),
        .out_be_o    (down_be_o),
        .out_data_o  (down_data_o),
        .out_ready_i (down_ready_i),
        .out_rdata_i (down_rdata_i)
    );

    pbv_dir #(.D (D)) u_up (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (s_valid_i),
        .in_fwd_i    (s_fwd),
        .in_cmd_i    (s_cmd_i),
        .in_addr_i   (s_addr_i),
        .in_be_i     (s_be_i),
        .in_data_i   (s_data_i),
        .in_done_o   (s_done_o),
        .in_retry_o  (s_retry_o),
        .in_rdata_o  (s_rdata_o),
        .out_valid_o (up_valid_o),
        .out_cmd_o   (up_cmd_o),
        .out_addr_o  (up_addr_o),
        .out_be_o    (up_be_o),
        .out_data_o  (up_data_o),
        .out_ready_i (up_ready_i),
        .out_rdata_i (up_rdata_i)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_fb_claim: assert property (p_valid_i && vga_mode_i && (p_cmd_i == `PBV_CMD_MEM_RD)
        && (p_addr_i >= `PBV_FB_LO) && (p_addr_i <= `PBV_FB_HI) |-> p_devsel_o) // [R1]
        else $error("Frame buffer access not claimed in VGA mode.");
    a_bios_skip: assert property (p_valid_i && !p_range_hit_i && (p_addr_i[31:16] == `PBV_BIOS_PAGE) |-> !p_devsel_o) // [R7]
        else $error("BIOS area claimed without a range hit.");
    a_up_vga_ignored: assert property (s_valid_i && s_vga |-> !s_devsel_o) // [R2]
        else $error("Secondary VGA access claimed for upstream.");
    a_snoop_claim: assert property (p_valid_i && vga_snoop_i && (p_cmd_i == `PBV_CMD_IO_WR)
        && (p_addr_i[31:16] == 16'h0000) && (p_addr_i[9:0] == `PBV_PAL_DATA) |-> p_devsel_o) // [R9]
        else $error("Palette write not claimed in snoop mode.");
    a_io_alias: assert property (p_valid_i && vga_mode_i && !p_range_hit_i && (p_cmd_i == `PBV_CMD_IO_RD)
        |-> p_devsel_o == ((p_addr_i[31:16] == 16'h0000) && (((p_addr_i[9:0] >= `PBV_IO_A_LO)
        && (p_addr_i[9:0] <= `PBV_IO_A_HI)) || ((p_addr_i[9:0] >= `PBV_IO_B_LO)
        && (p_addr_i[9:0] <= `PBV_IO_B_HI))))) // [R6]
        else $error("VGA port decode wrong.");

    c_vga_fwd: cover property (p_devsel_o && p_vga ##[1:10] down_valid_o);
endmodule

// ### verif/pbv_tgt_model.sv
// Far-side target model that answers launched transactions promptly or slowly.
`timescale 1ns/1ps
module pbv_tgt_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic        valid_i,
    input  wire logic [31:0] addr_i,
    output logic             ready_o,
    output logic [31:0]      rdata_o
);
    logic [3:0] wait_reg;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wait_reg <= 4'h0;
        else
            wait_reg <= (valid_i && !ready_o) ? wait_reg + 4'h1 : 4'h0;
    end
    // Every write is taken, whatever else is outstanding.
    assign ready_o = valid_i && (wait_reg >= (slow_i ? 4'h6 : 4'h1));
    // Outside ready the data toggles, so a stale capture cannot pass.
    assign rdata_o = ready_o ? ~addr_i : {8{wait_reg}};
endmodule

// ### verif/pbv_bridge_tb_top.sv
// Self-checking bench for the bridge decode and ordering block.
`timescale 1ns/1ps
module pbv_bridge_tb_top;
    logic clk_i, rst_b_i, vga_mode_i, vga_snoop_i, p_valid_i, p_range_hit_i, s_valid_i, s_range_hit_i;
    logic p_devsel_o, p_done_o, p_retry_o, s_devsel_o, s_done_o, s_retry_o;
    logic down_valid_o, down_ready_i, up_valid_o, up_ready_i, dn_slow, up_slow, dev, dn, rt;
    logic [3:0] p_cmd_i, p_be_i, s_cmd_i, s_be_i, down_cmd_o, down_be_o, up_cmd_o, up_be_o;
    logic [31:0] p_addr_i, p_data_i, p_rdata_o, s_addr_i, s_data_i, s_rdata_o;
    logic [31:0] down_addr_o, down_data_o, down_rdata_i, up_addr_o, up_data_o, up_rdata_i;
    int failures, comparisons;
    logic [3:0] dly_cmd [7] = '{4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hC, 4'hE};
    pbv_pkg::pbv_txn_t got_q[$], exp_q[$], up_q[$];
    pbv_bridge #(.D(4)) u_dut (.*);
    pbv_tgt_model u_dn (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(dn_slow), .valid_i(down_valid_o),
        .addr_i(down_addr_o), .ready_o(down_ready_i), .rdata_o(down_rdata_i));
    pbv_tgt_model u_up (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(up_slow), .valid_i(up_valid_o),
        .addr_i(up_addr_o), .ready_o(up_ready_i), .rdata_o(up_rdata_i));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Read data is masked so that only write payloads take part in the comparison.
    always @(posedge clk_i)
        if (down_valid_o && down_ready_i)
            got_q.push_back({down_cmd_o, down_addr_o, down_be_o, down_cmd_o[0] ? down_data_o : 32'h0});
    always @(posedge clk_i)
        if (up_valid_o && up_ready_i)
            up_q.push_back({up_cmd_o, up_addr_o, up_be_o, up_data_o});
    // ****************************************************************
    // Drivers and comparisons
    // ****************************************************************
    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_txn(input logic [71:0] got, input logic [71:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_txn({71'h0, got}, {71'h0, exp});
    endtask
    task automatic reset_dut();
        rst_b_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic xact(input bit s, input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] be);
        @(negedge clk_i);
        {p_cmd_i, s_cmd_i, p_addr_i, s_addr_i, p_data_i, s_data_i, p_be_i, s_be_i} = {c, c, a, a, d, d, be, be};
        p_valid_i = !s;
        s_valid_i = s;
        #5;
        {dev, dn, rt} = s ? {s_devsel_o, s_done_o, s_retry_o} : {p_devsel_o, p_done_o, p_retry_o};
        if (!s && dn === 1'b1 && (c == 4'h7 || c == 4'hF))
            exp_q.push_back({c, a, be, d});
        @(negedge clk_i);
        p_valid_i = 1'b0;
        s_valid_i = 1'b0;
    endtask
    task automatic drain();
        repeat (300) if (got_q.size() < exp_q.size()) @(negedge clk_i);
        chk_bit(got_q.size() == exp_q.size(), 1'b1);
        foreach (exp_q[i]) if (i < got_q.size()) chk_txn(got_q[i], exp_q[i]);
    endtask
    task automatic dec(input bit m, sn, s, input logic [3:0] c, input logic [31:0] a, input logic e);
        vga_mode_i = m;
        vga_snoop_i = sn;
        xact(s, c, a, 32'h0, 4'hF);
        chk_bit(dev, e);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_decode();
        p_range_hit_i = 1'b0;
        dec(1,0,0,4'h6,32'h000A_0000,1);
        dec(1,0,0,4'h7,32'h000B_FFFF,1);
        dec(1,0,0,4'h7,32'h0009_FFFF,0);
        dec(1,0,0,4'h7,32'h000C_0000,0);
        dec(1,0,0,4'h2,32'h0000_03BB,1);
        dec(1,0,0,4'h3,32'h0000_03BC,0);
        dec(1,0,0,4'h2,32'h0000_03DF,1);
        dec(1,0,0,4'h2,32'h0000_FFC0,1);
        dec(1,0,0,4'h2,32'h0001_03C0,0);
        dec(1,0,0,4'h6,32'h0000_03C0,0);
        dec(0,1,0,4'h3,32'h0000_7BC6,1);
        dec(0,1,0,4'h3,32'h0000_03C9,1);
        dec(0,1,0,4'h3,32'h0000_03C7,0);
        dec(0,1,0,4'h2,32'h0000_03C8,0);
        dec(1,1,0,4'h2,32'h0000_03B0,1);
        dec(1,0,1,4'h7,32'h000A_0000,0);
        dec(0,0,1,4'h7,32'h000A_0000,1);
        s_range_hit_i = 1'b1;
        dec(0,0,1,4'h7,32'h000A_0000,0);
        s_range_hit_i = 1'b0;
    endtask
    task automatic t_posted();
        int n = 0;
        {vga_mode_i, vga_snoop_i, p_range_hit_i, dn_slow, rt} = 5'h0E;
        while (rt !== 1'b1 && n < 8)
        begin
            xact(0, n[0] ? 4'hF : 4'h7, 32'h0010_0040, 32'hA5A5_0000 + n, 4'h1 << n[1:0]);
            n = n + ((dn === 1'b1) ? 1 : 0);
        end
        // Four entries held, one launched and one delivered by the slow target before the first refusal.
        chk_bit(n == 6, 1'b1);
        xact(1, 4'h7, 32'h0000_1000, 32'h0000_5A5A, 4'hF);
        chk_bit(dn, 1'b1);
        drain();
        chk_txn(up_q[$], {4'h7, 32'h0000_1000, 4'hF, 32'h0000_5A5A});
        dn_slow = 1'b0;
    endtask
    task automatic t_delay(input logic [3:0] c);
        int k = 0;
        xact(0, 4'h7, 32'h0010_0080, 32'h1111_2222, 4'hF);
        xact(0, c, 32'h0010_00C4, 32'h3333_4444, 4'h3);
        chk_bit(rt, 1'b1);
        exp_q.push_back({c, 32'h0010_00C4, 4'h3, c[0] ? 32'h3333_4444 : 32'h0});
        drain();
        xact(0, 4'h7, 32'h0010_0100, 32'h5555_6666, 4'hF);
        chk_bit(dn, 1'b1);
        dn = 1'b0;
        while (dn !== 1'b1 && k < 20)
        begin
            xact(0, c, 32'h0010_00C4, 32'h3333_4444, 4'h3);
            k++;
        end
        chk_bit(dn, 1'b1);
        if (!c[0]) chk_txn({40'h0, p_rdata_o}, {40'h0, ~32'h0010_00C4});
        drain();
    endtask
    initial
    begin
        {rst_b_i, vga_mode_i, vga_snoop_i, p_valid_i, p_range_hit_i, s_valid_i, s_range_hit_i} = 7'h0;
        {p_cmd_i, p_be_i, p_addr_i, p_data_i, s_cmd_i, s_be_i, s_addr_i, s_data_i} = 144'h0;
        {dn_slow, up_slow, failures, comparisons} = 66'h0;
        reset_dut();
        t_decode();
        reset_dut();
        t_posted();
        foreach (dly_cmd[i]) t_delay(dly_cmd[i]);
        conclude();
    end
    initial
    begin
        #1000000;
        failures++;
        conclude();
    end
endmodule
